// ===== cmd_seq_asserts.sv
// Timing checks on the link between host controller and reader device
`timescale 1ns/10ps
`default_nettype none
`include "cmd_seq_regs.svh"
module cmd_seq_asserts (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic rx_enable,
	input wire logic tx_active,
	input wire logic auth_active,
	input wire logic fifo_wr,
	input wire logic fifo_rd,
	input wire logic rx_frame_end,
	input wire logic tx_frame_end,
	input wire logic auth_done,
	input wire logic auth_fail
);
	logic cmd_wr;
	logic start_w;
	logic ev_any;
	logic start_q;
	assign cmd_wr = wr && addr == `CMDR_ADDR;
	assign start_w = wr && addr == `BITF_ADDR && wdata[`BITF_START_BIT];
	assign ev_any = rx_frame_end | tx_frame_end | auth_done | auth_fail;
	// Start request stays armed until the send phase shows
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			start_q <= 1'b0;
		end else begin
			start_q <= (start_q | start_w) & !tx_active;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	a_fifo_blocked: assert property (
		auth_active |-> !fifo_wr && !fifo_rd)
		else $error("fifo strobe while authenticating");
	a_recv_entry: assert property (
		cmd_wr && wdata[3:0] == 4'h8 |=> rx_enable && !tx_active)
		else $error("receive code did not open receiver");
	a_auth_entry: assert property (
		cmd_wr && wdata[3:0] == 4'he |=> auth_active && !rx_enable)
		else $error("authentication code not taken");
	a_keep_code: assert property (
		cmd_wr && wdata[3:0] == 4'h7 && !ev_any
		|=> $stable({rx_enable, tx_active, auth_active}))
		else $error("keep code changed the running command");
	a_idle_abort: assert property (
		cmd_wr && wdata[3:0] == 4'h0
		|=> !rx_enable && !tx_active && !auth_active)
		else $error("idle code did not abort");
	a_tx_needs_start: assert property (
		$rose(tx_active) |-> start_q)
		else $error("send began without start bit");
	a_tx_then_recv: assert property (
		tx_active && tx_frame_end && !cmd_wr |=> rx_enable && !tx_active)
		else $error("send did not turn to receive");
	a_auth_ends: assert property (
		auth_active && (auth_done || auth_fail) && !cmd_wr |=> !auth_active)
		else $error("authentication did not end");
	cover property (auth_active && auth_done);
	cover property (auth_active && auth_fail);
	cover property ($rose(tx_active));
	cover property (rx_enable && rx_frame_end);
endmodule
`default_nettype wire

// ===== cmd_seq_dev.sv
// Reader device end: command register, sequencer and status
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "cmd_seq_regs.svh"
module cmd_seq_dev (
	input wire logic core_clk,
	input wire logic sys_rst,
	cmd_seq_if.dev bus,
	input wire logic rx_frame_end,
	input wire logic tx_frame_end,
	input wire logic auth_done,
	input wire logic auth_fail,
	output logic rx_enable,
	output logic tx_active,
	output logic auth_active,
	output logic [7:0] fifo_wdata,
	output logic fifo_wr,
	output logic fifo_rd,
	input wire logic [7:0] fifo_rdata,
	input wire logic [6:0] fifo_level
);
	logic [7:0] cmdr_q;
	logic [7:0] irq_q;
	logic [7:0] err_q;
	logic [7:0] stat2_q;
	logic [7:0] bitf_q;
	logic [7:0] rxcfg_q;
	logic [7:0] tmode_q;
	logic [7:0] tpre_q;
	logic [7:0] trel_q;
	logic [7:0] srate_q;
	logic [7:0] demod_q;
	logic [7:0] rdata_q;
	cmd_seq_pkg::seq_state_e st_q;
	logic timer_exp;
	logic cmd_wr;
	logic new_cmd;
	logic self_end;
	logic soft_rst;
	logic fifo_touch;
	logic multi;

	assign cmd_wr = bus.wr && bus.addr == `CMDR_ADDR;
	// Keep code never replaces the running command
	assign new_cmd = cmd_wr &&
		bus.wdata[`CMD_MSB:`CMD_LSB] != cmd_seq_pkg::CMD_KEEP;
	assign multi = rxcfg_q[`RXCFG_MULTI_BIT];
	assign soft_rst = st_q == cmd_seq_pkg::ST_SRST;
	assign fifo_touch = (bus.wr || bus.rd) && bus.addr == `FIFOD_ADDR;
	assign self_end = !new_cmd && (
		(st_q == cmd_seq_pkg::ST_RECV && rx_frame_end && !multi) ||
		(st_q == cmd_seq_pkg::ST_AUTH && (auth_done || auth_fail)) ||
		soft_rst);

	assign rx_enable = (st_q == cmd_seq_pkg::ST_RECV ||
		st_q == cmd_seq_pkg::ST_XRECV) && !cmdr_q[`RCV_OFF_BIT];
	assign tx_active = st_q == cmd_seq_pkg::ST_XSEND;
	assign auth_active = st_q == cmd_seq_pkg::ST_AUTH;
	// FIFO blocked while authenticating
	assign fifo_wr = bus.wr && bus.addr == `FIFOD_ADDR && !auth_active;
	assign fifo_rd = bus.rd && bus.addr == `FIFOD_ADDR && !auth_active;
	assign fifo_wdata = bus.wdata;
	assign bus.rdata = rdata_q;

	ref_tick #(
		.PRE_W(12),
		.REL_W(8)
	) u_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst || soft_rst),
		.run(tmode_q[`TMODE_AUTO_BIT] && st_q != cmd_seq_pkg::ST_IDLE),
		.prescale({tmode_q[3:0], tpre_q}),
		.reload(trel_q),
		.expired(timer_exp)
	);

	// Sequencer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= cmd_seq_pkg::ST_IDLE;
		end else if (new_cmd) begin
			case (bus.wdata[`CMD_MSB:`CMD_LSB])
				cmd_seq_pkg::CMD_RECV: st_q <= cmd_seq_pkg::ST_RECV;
				cmd_seq_pkg::CMD_XCV: st_q <= cmd_seq_pkg::ST_XWAIT;
				cmd_seq_pkg::CMD_AUTH: st_q <= cmd_seq_pkg::ST_AUTH;
				cmd_seq_pkg::CMD_SRST: st_q <= cmd_seq_pkg::ST_SRST;
				default: st_q <= cmd_seq_pkg::ST_IDLE;
			endcase
		end else begin
			case (st_q)
				cmd_seq_pkg::ST_XWAIT:
					if (bitf_q[`BITF_START_BIT])
						st_q <= cmd_seq_pkg::ST_XSEND;
				cmd_seq_pkg::ST_XSEND:
					if (tx_frame_end)
						st_q <= cmd_seq_pkg::ST_XRECV;
				cmd_seq_pkg::ST_XRECV:
					// Loop back forever; multi-frame never leaves receive
					if (rx_frame_end && !multi)
						st_q <= cmd_seq_pkg::ST_XWAIT;
				default:
					if (self_end)
						st_q <= cmd_seq_pkg::ST_IDLE;
			endcase
		end
	end

	// Command register
	always_ff @(posedge core_clk) begin
		if (sys_rst || soft_rst) begin
			cmdr_q <= `CMDR_RESET;
		end else if (cmd_wr) begin
			cmdr_q[7:4] <= bus.wdata[7:4];
			if (new_cmd)
				cmdr_q[3:0] <= bus.wdata[3:0];
		end else if (self_end) begin
			cmdr_q[3:0] <= cmd_seq_pkg::CMD_IDLE;
		end
	end

	// Interrupt flags: set wins over write-one-to-clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_q <= 8'h00;
		end else if (soft_rst) begin
			// Soft reset clears the flags but still reports its own end
			irq_q <= 8'h00;
			irq_q[`IRQ_IDLE_BIT] <= 1'b1;
		end else begin
			if (bus.wr && bus.addr == `IRQR_ADDR)
				irq_q <= irq_q & ~bus.wdata;
			if (self_end)
				irq_q[`IRQ_IDLE_BIT] <= 1'b1;
			if (timer_exp)
				irq_q[`IRQ_TIMER_BIT] <= 1'b1;
			if (rx_frame_end && rx_enable && !auth_active)
				irq_q[`IRQ_RX_BIT] <= 1'b1;
			if (tx_frame_end && tx_active && !auth_active)
				irq_q[`IRQ_TX_BIT] <= 1'b1;
		end
	end

	// Error flags; a write clears, a new error wins
	always_ff @(posedge core_clk) begin
		if (sys_rst || soft_rst) begin
			err_q <= 8'h00;
		end else begin
			if (bus.wr && bus.addr == `ERRR_ADDR)
				err_q <= 8'h00;
			if (auth_active && fifo_touch)
				err_q[`ERR_WR_BIT] <= 1'b1;
			if (auth_active && auth_fail && !new_cmd)
				err_q[`ERR_PROTO_BIT] <= 1'b1;
		end
	end

	// Cipher status, meaningful only once authentication is over
	always_ff @(posedge core_clk) begin
		if (sys_rst || soft_rst) begin
			stat2_q <= 8'h00;
		end else if (auth_active && auth_fail && !new_cmd) begin
			stat2_q[`STAT2_CIPHER_BIT] <= 1'b0;
		end else if (auth_active && auth_done && !new_cmd) begin
			stat2_q[`STAT2_CIPHER_BIT] <= 1'b1;
		end else if (bus.wr && bus.addr == `STAT2_ADDR) begin
			stat2_q[`STAT2_CIPHER_BIT] <= bus.wdata[`STAT2_CIPHER_BIT];
		end
	end

	// Start bit clears itself once the send phase begins
	always_ff @(posedge core_clk) begin
		if (sys_rst || soft_rst)
			bitf_q <= 8'h00;
		else if (bus.wr && bus.addr == `BITF_ADDR)
			bitf_q <= bus.wdata;
		else if (st_q == cmd_seq_pkg::ST_XWAIT && bitf_q[`BITF_START_BIT])
			bitf_q[`BITF_START_BIT] <= 1'b0;
	end

	// Plain configuration registers
	always_ff @(posedge core_clk) begin
		if (sys_rst || soft_rst) begin
			rxcfg_q <= `RXCFG_RESET;
			tmode_q <= `TMODE_RESET;
			tpre_q <= 8'h00;
			trel_q <= 8'h00;
			demod_q <= 8'h00;
			srate_q <= `SRATE_RESET;
		end else if (bus.wr) begin
			case (bus.addr)
				`RXCFG_ADDR: rxcfg_q <= bus.wdata;
				`TMODE_ADDR: tmode_q <= bus.wdata;
				`TPRE_ADDR: tpre_q <= bus.wdata;
				`TREL_ADDR: trel_q <= bus.wdata;
				`DEMOD_ADDR: demod_q <= bus.wdata;
				`SRATE_ADDR: srate_q <= bus.wdata;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				`CMDR_ADDR: rdata_q <= cmdr_q;
				`IRQR_ADDR: rdata_q <= irq_q;
				`ERRR_ADDR: rdata_q <= err_q;
				`STAT2_ADDR: rdata_q <= stat2_q;
				`FIFOD_ADDR: rdata_q <= auth_active ? 8'h00 : fifo_rdata;
				`FIFOL_ADDR: rdata_q <= {1'b0, fifo_level};
				`BITF_ADDR: rdata_q <= bitf_q;
				`RXCFG_ADDR: rdata_q <= rxcfg_q;
				`TMODE_ADDR: rdata_q <= tmode_q;
				`TPRE_ADDR: rdata_q <= tpre_q;
				`TREL_ADDR: rdata_q <= trel_q;
				`DEMOD_ADDR: rdata_q <= demod_q;
				`SRATE_ADDR: rdata_q <= srate_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== cmd_seq_host.sv
// Host controller end: runs one command per order
`timescale 1ns/10ps
`default_nettype none
`include "cmd_seq_regs.svh"
module cmd_seq_host (
	input wire logic core_clk,
	input wire logic sys_rst,
	cmd_seq_if.host bus,
	input wire logic [3:0] order_cmd,
	input wire logic [7:0] order_bits,
	input wire logic order_go,
	input wire logic [95:0] auth_args,
	output logic busy,
	output logic [7:0] last_irq,
	output logic done
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_TMODE = 3'b001,
		H_LOAD = 3'b010,
		H_CMD = 3'b011,
		H_POLL = 3'b100,
		H_WAIT = 3'b101,
		H_START = 3'b110,
		H_GAP = 3'b111
	} host_state_e;

	host_state_e st_q;
	logic [3:0] cmd_q;
	logic [7:0] bits_q;
	logic [95:0] args_q;
	logic [3:0] idx_q;
	logic take;

	assign take = order_go && (st_q == H_IDLE || st_q == H_POLL ||
		st_q == H_GAP || st_q == H_WAIT);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= H_IDLE;
			cmd_q <= 4'h0;
			bits_q <= 8'h00;
			args_q <= '0;
			idx_q <= 4'h0;
			bus.addr <= 6'h00;
			bus.wdata <= 8'h00;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			last_irq <= 8'h00;
			done <= 1'b0;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			done <= 1'b0;
			case (st_q)
				H_IDLE: ;
				H_TMODE: begin
					bus.addr <= `DEMOD_ADDR;
					bus.wdata <= 8'h00;
					bus.wr <= 1'b1;
					st_q <= H_LOAD;
				end
				H_LOAD: begin
					bus.addr <= `FIFOD_ADDR;
					bus.wdata <= args_q[95:88];
					bus.wr <= 1'b1;
					args_q <= {args_q[87:0], 8'h00};
					idx_q <= idx_q + 4'h1;
					if (idx_q == 4'(`AUTH_ARG_BYTES - 1))
						st_q <= H_CMD;
				end
				H_CMD: begin
					bus.addr <= `CMDR_ADDR;
					bus.wdata <= {bits_q[7:4], cmd_q};
					bus.wr <= 1'b1;
					st_q <= cmd_q == cmd_seq_pkg::CMD_XCV ? H_START : H_POLL;
				end
				H_START: begin
					bus.addr <= `BITF_ADDR;
					bus.wdata <= 8'h80;
					bus.wr <= 1'b1;
					st_q <= H_IDLE;
					done <= 1'b1;
				end
				H_POLL: begin
					bus.addr <= `IRQR_ADDR;
					bus.rd <= 1'b1;
					st_q <= H_GAP;
				end
				// Read data appear in the cycle after the strobe and hold until the next read
				H_GAP: st_q <= H_WAIT;
				H_WAIT:
					if (bus.rdata[`IRQ_IDLE_BIT] ||
						(cmd_q == cmd_seq_pkg::CMD_AUTH &&
						bus.rdata[`IRQ_TIMER_BIT]) ||
						cmd_q == cmd_seq_pkg::CMD_KEEP ||
						cmd_q == cmd_seq_pkg::CMD_IDLE) begin
						last_irq <= bus.rdata;
						bus.addr <= `IRQR_ADDR;
						bus.wdata <= bus.rdata;
						bus.wr <= 1'b1;
						done <= 1'b1;
						st_q <= H_IDLE;
					end else begin
						st_q <= H_POLL;
					end
				default: st_q <= H_IDLE;
			endcase
			// A new order may cut a poll short: a command that never
			// ends by itself needs another code from the host
			if (take) begin
				cmd_q <= order_cmd;
				bits_q <= order_bits;
				args_q <= auth_args;
				idx_q <= 4'h0;
				done <= 1'b0;
				// Timer auto mode guards a silent card; even select stays 0
				if (order_cmd == cmd_seq_pkg::CMD_AUTH) begin
					bus.addr <= `TMODE_ADDR;
					bus.wdata <= 8'h80;
					bus.wr <= 1'b1;
					st_q <= H_TMODE;
				end else begin
					st_q <= H_CMD;
				end
			end
		end
	end

	assign busy = st_q != H_IDLE;
endmodule
`default_nettype wire

// ===== cmd_seq_if.sv
// Register link between host controller and reader device
`timescale 1ns/10ps
`default_nettype none
interface cmd_seq_if;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;

	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input rdata
	);
	modport dev (
		input addr,
		input wdata,
		input wr,
		input rd,
		output rdata
	);
endinterface
`default_nettype wire

// ===== cmd_seq_pkg.sv
// Types shared by the command sequencer ends
package cmd_seq_pkg;

	typedef enum logic [3:0] {
		CMD_IDLE = 4'h0,
		CMD_KEEP = 4'h7,
		CMD_RECV = 4'h8,
		CMD_XCV = 4'hc,
		CMD_RSVD = 4'hd,
		CMD_AUTH = 4'he,
		CMD_SRST = 4'hf
	} cmd_code_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RECV = 3'b001,
		ST_XWAIT = 3'b010,
		ST_XSEND = 3'b011,
		ST_XRECV = 3'b100,
		ST_AUTH = 3'b101,
		ST_SRST = 3'b110
	} seq_state_e;

endpackage

// ===== cmd_seq_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CMD_SEQ_REGS_SVH
`define CMD_SEQ_REGS_SVH

// Device register addresses (6-bit)
`define CMDR_ADDR 6'h01
`define IRQR_ADDR 6'h04
`define ERRR_ADDR 6'h06
`define STAT2_ADDR 6'h08
`define FIFOD_ADDR 6'h09
`define FIFOL_ADDR 6'h0a
`define BITF_ADDR 6'h0d
`define RXCFG_ADDR 6'h13
`define TMODE_ADDR 6'h2a
`define TPRE_ADDR 6'h2b
`define TREL_ADDR 6'h2c
`define SRATE_ADDR 6'h1f
`define DEMOD_ADDR 6'h19

// Command register fields
`define CMD_LSB 0
`define CMD_MSB 3
`define RCV_OFF_BIT 5
`define SOFT_A_BIT 4
// Interrupt flag bits
`define IRQ_TIMER_BIT 0
`define IRQ_IDLE_BIT 4
`define IRQ_RX_BIT 5
`define IRQ_TX_BIT 6
// Error flag bits
`define ERR_PROTO_BIT 0
`define ERR_WR_BIT 7
// Status-two bit
`define STAT2_CIPHER_BIT 3
// Bit framing start bit
`define BITF_START_BIT 7
// Receive config multi-frame bit
`define RXCFG_MULTI_BIT 2
// Demod even prescale select
`define DEMOD_EVEN_BIT 4
// Timer automatic mode bit
`define TMODE_AUTO_BIT 7

// Reset values
`define SRATE_RESET 8'heb
`define TMODE_RESET 8'h00
`define RXCFG_RESET 8'h00
`define CMDR_RESET 8'h20

// Authentication argument bytes
`define AUTH_ARG_BYTES 12
`define AUTH_KEY_A 8'h60
`define AUTH_KEY_B 8'h61

// Reference clock 13.56 MHz, core clock 250 MHz, both in kHz
`define REF_KHZ 13560
`define CORE_KHZ 250000
`define REF_ACC_W 18

`endif

// ===== contactless_cmd_sequencer_tb.sv
// Bench joining host controller and reader device over the register link
`timescale 1ns/10ps
`default_nettype none
`include "cmd_seq_regs.svh"
module contactless_cmd_sequencer_tb;
	logic core_clk, sys_rst, order_go, busy, done;
	logic rx_enable, tx_active, auth_active, fifo_wr, fifo_rd;
	logic [3:0] order_cmd, ev;
	logic [7:0] order_bits, last_irq, fifo_wdata, fifo_rdata, code;
	logic [95:0] auth_args;
	logic [6:0] fifo_level;
	logic [7:0] fifo_log[$];
	int mismatches, compares;
	cmd_seq_if cmd_seq_if_i();
	cmd_seq_host cmd_seq_host_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.bus(cmd_seq_if_i.host), .order_cmd(order_cmd),
		.order_bits(order_bits), .order_go(order_go), .auth_args(auth_args),
		.busy(busy), .last_irq(last_irq), .done(done));
	cmd_seq_dev cmd_seq_dev_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.bus(cmd_seq_if_i.dev), .rx_frame_end(ev[3]), .tx_frame_end(ev[2]),
		.auth_done(ev[1]), .auth_fail(ev[0]), .rx_enable(rx_enable),
		.tx_active(tx_active), .auth_active(auth_active),
		.fifo_wdata(fifo_wdata), .fifo_wr(fifo_wr), .fifo_rd(fifo_rd),
		.fifo_rdata(fifo_rdata), .fifo_level(fifo_level));
	cmd_seq_asserts cmd_seq_asserts_i (.core_clk(core_clk),
		.sys_rst(sys_rst), .addr(cmd_seq_if_i.addr),
		.wdata(cmd_seq_if_i.wdata), .wr(cmd_seq_if_i.wr),
		.rd(cmd_seq_if_i.rd), .rx_enable(rx_enable), .tx_active(tx_active),
		.auth_active(auth_active), .fifo_wr(fifo_wr), .fifo_rd(fifo_rd),
		.rx_frame_end(ev[3]), .tx_frame_end(ev[2]), .auth_done(ev[1]),
		.auth_fail(ev[0]));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		// Log what reaches the buffer, so blocked writes show up
		if (fifo_wr) begin
			fifo_log.push_back(fifo_wdata);
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic timed_out();
		mismatches++;
		$display("ERROR at %0t: wait ran out", $time);
		give_verdict();
	endtask
	// Expected {rx_enable, tx_active, auth_active} once a code is taken
	function automatic logic [2:0] exp_act(input logic [3:0] c);
		case (c)
			4'h8: exp_act = 3'b100;
			4'hc: exp_act = 3'b010;
			4'he: exp_act = 3'b001;
			default: exp_act = 3'b000;
		endcase
	endfunction
	task automatic wait_act(input logic [2:0] want);
		int n;
		n = 0;
		while ({rx_enable, tx_active, auth_active} !== want && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		if (n == 300) timed_out();
		check({5'h00, rx_enable, tx_active, auth_active}, {5'h00, want});
	endtask
	task automatic start_order(input logic [3:0] c);
		@(posedge core_clk);
		order_cmd <= c;
		// Receiver-off and power-down bits stay clear
		order_bits <= {2'($urandom), 6'h00};
		order_go <= 1'b1;
		@(posedge core_clk);
		order_go <= 1'b0;
	endtask
	task automatic order(input logic [3:0] c);
		int n;
		n = 0;
		start_order(c);
		do begin
			@(negedge core_clk);
			n++;
		end while (done !== 1'b1 && n < 600);
		if (n == 600) timed_out();
	endtask
	task automatic pulse(input logic [3:0] e);
		@(posedge core_clk);
		ev <= e;
		@(posedge core_clk);
		ev <= 4'h0;
	endtask
	initial begin
		sys_rst = 1'b1;
		order_cmd = 4'h0;
		order_bits = 8'h20;
		order_go = 1'b0;
		auth_args = '0;
		ev = 4'h0;
		fifo_rdata = 8'h00;
		fifo_level = 7'h00;
		mismatches = 0;
		compares = 0;
		void'($urandom(4));
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			fifo_rdata <= 8'($urandom);
			fifo_level <= 7'($urandom);
			// Receive keeps the host polling; the next order cuts in
			start_order(4'h8);
			wait_act(exp_act(4'h8));
			order(4'h7);
			wait_act(3'b100);
			check(cmd_seq_dev_i.cmdr_q, {order_bits[7:4], 4'h8});
			pulse(4'h8);
			wait_act(3'b000);
			check(cmd_seq_dev_i.cmdr_q & 8'h0f, 8'h00);
			check(cmd_seq_dev_i.irq_q & 8'h30, 8'h30);
			start_order(4'h8);
			wait_act(exp_act(4'h8));
			order((i % 2) ? 4'hf : 4'h0);
			wait_act(3'b000);
		end
		// Transceive never ends by itself, so idle must close it
		for (int i = 0; i < 2; i++) begin
			order(4'hc);
			wait_act(exp_act(4'hc));
			pulse(4'h4);
			wait_act(3'b100);
			pulse(4'h8);
			repeat (20) @(negedge core_clk);
			check({5'h00, rx_enable, tx_active, auth_active}, 8'h00);
			check(cmd_seq_dev_i.irq_q & 8'h70, 8'h60);
			order(4'h0);
			wait_act(3'b000);
			check(cmd_seq_dev_i.cmdr_q & 8'h0f, 8'h00);
		end
		for (int i = 0; i < 2; i++) begin
			fifo_log.delete();
			code = 8'h60 | 8'($urandom_range(1));
			auth_args = {code, 32'($urandom), 32'($urandom), 24'($urandom)};
			fork
				order(4'he);
				begin
					wait_act(exp_act(4'he));
					pulse(4'h8);
					pulse(4'h4);
					pulse(i ? 4'h1 : 4'h2);
				end
			join
			check(8'(fifo_log.size()), 8'd12);
			check(fifo_log[0], code);
			for (int k = 0; k < 12; k++)
				check(fifo_log[k], auth_args[95 - 8 * k -: 8]);
			check(last_irq & 8'h70, 8'h10);
			check(cmd_seq_dev_i.stat2_q, i ? 8'h00 : 8'h08);
			check(cmd_seq_dev_i.err_q, i ? 8'h01 : 8'h00);
			wait_act(3'b000);
		end
		give_verdict();
	end
endmodule
`default_nettype wire

// ===== ref_tick.sv
// Fractional divider giving 13.56 MHz reference ticks and the timer
`timescale 1ns/10ps
`default_nettype none
`include "cmd_seq_regs.svh"
module ref_tick #(
	parameter int PRE_W = 12,
	parameter int REL_W = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic [PRE_W-1:0] prescale,
	input wire logic [REL_W-1:0] reload,
	output logic expired
);
	if (PRE_W < 1 || PRE_W > 16 || REL_W < 1 || REL_W > 16) begin : g_bad_width
		$error("ref_tick: unsupported width");
	end

	localparam logic [`REF_ACC_W-1:0] STEP = `REF_ACC_W'(`REF_KHZ);
	localparam logic [`REF_ACC_W-1:0] WRAP = `REF_ACC_W'(`CORE_KHZ);
	logic [`REF_ACC_W-1:0] acc_q;
	logic ref_q;
	logic [PRE_W:0] pre_cnt_q;
	logic [REL_W:0] rel_cnt_q;
	logic first_q;
	logic [`REF_ACC_W:0] acc_sum;

	// Extra bit keeps the carry; a narrow sum would wrap and drop ticks
	assign acc_sum = {1'b0, acc_q} + {1'b0, STEP};

	// Phase accumulator: average tick rate equals the reference clock
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			acc_q <= '0;
			ref_q <= 1'b0;
		end else if (acc_sum >= {1'b0, WRAP}) begin
			acc_q <= `REF_ACC_W'(acc_sum - {1'b0, WRAP});
			ref_q <= 1'b1;
		end else begin
			acc_q <= acc_sum[`REF_ACC_W-1:0];
			ref_q <= 1'b0;
		end
	end

	// Period is ((2*prescale+1)*reload+1) reference ticks
	always_ff @(posedge core_clk) begin
		if (sys_rst || !run) begin
			pre_cnt_q <= '0;
			rel_cnt_q <= '0;
			first_q <= 1'b1;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (ref_q) begin
				if (first_q) begin
					first_q <= 1'b0;
					rel_cnt_q <= {1'b0, reload};
					pre_cnt_q <= {prescale, 1'b0};
				end else if (pre_cnt_q != '0) begin
					pre_cnt_q <= pre_cnt_q - 1'b1;
				end else if (rel_cnt_q > 1) begin
					rel_cnt_q <= rel_cnt_q - 1'b1;
					pre_cnt_q <= {prescale, 1'b0};
				end else begin
					expired <= 1'b1;
					first_q <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire
